// file: hdl/int_vec_map.sv
// Fixed-priority interrupt vector map with pending-flag view registers
`timescale 1ns/1ps
`default_nettype none
module int_vec_map (
    input  wire logic                             mclk,
    input  wire logic                             rst,
    input  wire logic [int_vec_pkg::NUM_FLAGS:1] irq_req,      // Peripheral request lines, same clock
    input  wire logic                             swi_req,      // Software interrupt instruction
    input  wire logic                             irq_mask,     // Core interrupt mask, high blocks
    input  wire logic                             vec_ack,      // Core has taken the offered vector
    output logic                                  vec_valid,
    output logic [4:0]                            vec_source,
    output logic [15:0]                           vec_high_addr,
    output logic [15:0]                           vec_low_addr,
    output logic                                  vec_is_reset,
    output logic [7:0]                            pending_flags_reg_one,
    output logic [7:0]                            pending_flags_reg_two,
    output logic [7:0]                            pending_flags_reg_three
);
    int_vec_pkg::vec_answer_t ans_reg;
    int_vec_pkg::vec_answer_t ans_next;
    int_vec_pkg::flag_view_t  view_reg;
    int_vec_pkg::flag_view_t  view_next;
    logic                     boot_reg;
    logic                     boot_next;
    logic [int_vec_pkg::FLAG_W-1:0] pend;
    logic                     any_pend;
    logic [4:0]               win_idx;
    logic [15:0]              win_vec;

    assign pend = {irq_req, 1'b0};

    // Highest-priority pending flag
    // winner selection
    vec_encoder u_enc (
        .pending (pend),
        .any     (any_pend),
        .index   (win_idx)
    );

    // Vector for a flag number: flag n sits n pairs below the software vector
    // vector table
    always_comb begin
        win_vec = int_vec_pkg::VEC_SOFTWARE - 16'(win_idx) * int_vec_pkg::VEC_STEP;
    end

    // Pending-flag views, rebuilt every cycle from the request lines
    // register one, two and three layouts
    always_comb begin
        view_next = '0;
        for (int i = 0; i < int_vec_pkg::REG1_CNT; i++) begin
            view_next.one[i + int_vec_pkg::REG1_LO_BIT] = irq_req[i + int_vec_pkg::REG1_LO_FLAG];
        end
        for (int i = 0; i < int_vec_pkg::REG2_CNT; i++) begin
            view_next.two[i] = irq_req[i + int_vec_pkg::REG2_LO_FLAG];
        end
        for (int i = 0; i < int_vec_pkg::REG3_CNT; i++) begin
            view_next.three[i] = irq_req[i + int_vec_pkg::REG3_LO_FLAG];
        end
    end

    // Vector offer: reset vector first after reset, then software, then peripherals
    // pair and ranking
    always_comb begin
        ans_next  = ans_reg;
        boot_next = boot_reg;
        if (ans_reg.valid && vec_ack) begin
            ans_next.valid = 1'b0;
            boot_next      = 1'b0;
        end else if (!ans_reg.valid) begin
            if (boot_reg) begin
                ans_next.valid    = 1'b1;
                ans_next.source   = 5'h00;
                ans_next.vec_high = int_vec_pkg::VEC_RESET;
            end else if (swi_req) begin
                ans_next.valid    = 1'b1;
                ans_next.source   = 5'h00;
                ans_next.vec_high = int_vec_pkg::VEC_SOFTWARE;
            end else if (any_pend && !irq_mask) begin
                ans_next.valid    = 1'b1;
                ans_next.source   = win_idx;
                ans_next.vec_high = win_vec;
            end
            ans_next.vec_low = ans_next.vec_high + int_vec_pkg::VEC_LOW_OFFSET;
        end
    end

    // State registers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ans_reg  <= '0;
            view_reg <= '{one: int_vec_pkg::FLAG_REG_RESET, two: int_vec_pkg::FLAG_REG_RESET,
                          three: int_vec_pkg::FLAG_REG_RESET};
            boot_reg <= 1'b1;
        end else begin
            ans_reg  <= ans_next;
            view_reg <= view_next;
            boot_reg <= boot_next;
        end
    end

    // Outputs straight from flops
    assign vec_valid               = ans_reg.valid;
    assign vec_source              = ans_reg.source;
    assign vec_high_addr           = ans_reg.vec_high;
    assign vec_low_addr            = ans_reg.vec_low;
    assign vec_is_reset            = boot_reg;
    assign pending_flags_reg_one   = view_reg.one;
    assign pending_flags_reg_two   = view_reg.two;
    assign pending_flags_reg_three = view_reg.three;
endmodule
`default_nettype wire

// file: hdl/int_vec_pkg.sv
// Package with vector addresses, flag positions and carrier types for the vector map
package int_vec_pkg;
    localparam int          NUM_FLAGS      = 20;
    localparam int          FLAG_W         = 21;      // Bit 0 unused, flags 1..20
    localparam logic [15:0] VEC_CAN_TX     = 16'hFFD4;
    localparam logic [15:0] VEC_CAN_RX     = 16'hFFD6;
    localparam logic [15:0] VEC_CAN_ERR    = 16'hFFD8;
    localparam logic [15:0] VEC_CAN_WAKE   = 16'hFFDA;
    localparam logic [15:0] VEC_TIMEBASE   = 16'hFFDC;
    localparam logic [15:0] VEC_CONVERSION = 16'hFFDE;
    localparam logic [15:0] VEC_KEYBOARD   = 16'hFFE0;
    localparam logic [15:0] VEC_ASYNC_TX   = 16'hFFE2;
    localparam logic [15:0] VEC_ASYNC_RX   = 16'hFFE4;
    localparam logic [15:0] VEC_ASYNC_ERR  = 16'hFFE6;
    localparam logic [15:0] VEC_SYNC_TX    = 16'hFFE8;
    localparam logic [15:0] VEC_SYNC_RX    = 16'hFFEA;
    localparam logic [15:0] VEC_T2_OVF     = 16'hFFEC;
    localparam logic [15:0] VEC_T2_CH1     = 16'hFFEE;
    localparam logic [15:0] VEC_T2_CH0     = 16'hFFF0;
    localparam logic [15:0] VEC_T1_OVF     = 16'hFFF2;
    localparam logic [15:0] VEC_T1_CH1     = 16'hFFF4;
    localparam logic [15:0] VEC_T1_CH0     = 16'hFFF6;
    localparam logic [15:0] VEC_PLL        = 16'hFFF8;
    localparam logic [15:0] VEC_EXT_PIN    = 16'hFFFA;
    localparam logic [15:0] VEC_SOFTWARE   = 16'hFFFC;
    localparam logic [15:0] VEC_RESET      = 16'hFFFE;
    localparam logic [15:0] VEC_LOW_OFFSET = 16'h0001; // Low byte follows high byte
    localparam logic [15:0] VEC_STEP       = 16'h0002; // One flag step per vector pair
    // Flag registers: one holds flags 6..1 in bits 7..2, two holds 14..7, three holds 20..15
    localparam int          REG1_LO_FLAG   = 1;
    localparam int          REG1_LO_BIT    = 2;
    localparam int          REG2_LO_FLAG   = 7;
    localparam int          REG3_LO_FLAG   = 15;
    localparam int          REG1_CNT       = 6;
    localparam int          REG2_CNT       = 8;
    localparam int          REG3_CNT       = 6;
    localparam logic [7:0]  FLAG_REG_RESET = 8'h00;

    // Vector answer handed to the core
    typedef struct packed {
        logic        valid;
        logic [4:0]  source;   // Flag number, 0 for software, reset separate
        logic [15:0] vec_high; // Address of high byte
        logic [15:0] vec_low;  // Address of low byte
    } vec_answer_t;

    // Pending flag view
    typedef struct packed {
        logic [7:0] one;
        logic [7:0] two;
        logic [7:0] three;
    } flag_view_t;
endpackage

// file: hdl/vec_encoder.sv
// Priority encoder: picks the lowest-numbered (highest-priority) pending flag
`timescale 1ns/1ps
`default_nettype none
module vec_encoder (
    input  wire logic [int_vec_pkg::FLAG_W-1:0] pending,
    output logic                                 any,
    output logic [4:0]                           index
);
    // Flag 1 outranks flag 20, so scan from the top down and let low numbers win
    always_comb begin
        any   = 1'b0;
        index = 5'h00;
        for (int i = int_vec_pkg::NUM_FLAGS; i >= 1; i--) begin
            if (pending[i]) begin
                any   = 1'b1;
                index = 5'(i);
            end
        end
    end
endmodule
`default_nettype wire

// file: sim/core_model.sv
// Processor core stand-in that takes offered vectors
`timescale 1ns/1ps
`default_nettype none
module core_model (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       vec_valid,
    input  wire logic [3:0] lat,
    output logic            vec_ack
);
    logic [3:0] cnt_reg;
    // One-cycle acknowledge after lat+1 cycles of an offer
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_reg <= 4'h0;
            vec_ack <= 1'b0;
        end else begin
            vec_ack <= vec_valid && !vec_ack && cnt_reg == lat;
            cnt_reg <= (vec_valid && !vec_ack && cnt_reg != lat) ? cnt_reg + 4'h1 : 4'h0;
        end
    end
endmodule
`default_nettype wire

// file: sim/int_vec_map_asserts.sv
// Port checks for the vector map
`timescale 1ns/1ps
`default_nettype none
module int_vec_map_asserts (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic [20:1] irq_req,
    input wire logic        swi_req,
    input wire logic        irq_mask,
    input wire logic        vec_ack,
    input wire logic        vec_valid,
    input wire logic [4:0]  vec_source,
    input wire logic [15:0] vec_high_addr,
    input wire logic [15:0] vec_low_addr,
    input wire logic        vec_is_reset,
    input wire logic [7:0]  pending_flags_reg_one,
    input wire logic [7:0]  pending_flags_reg_two,
    input wire logic [7:0]  pending_flags_reg_three
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // Offer still waiting, and a fresh peripheral offer
    sequence s_wait; vec_valid && !vec_ack; endsequence
    sequence s_new; $rose(vec_valid) && vec_source != 5'h00; endsequence
    property p_pair; vec_valid |-> vec_low_addr == vec_high_addr + 16'h0001; endproperty
    a_pair: assert property (p_pair) else $error("low byte address");
    property p_map; vec_valid && vec_source != 5'h00
        |-> vec_high_addr == 16'hFFFC - {10'h000, vec_source, 1'b0}; endproperty
    a_map: assert property (p_map) else $error("flag vector");
    property p_swi; vec_valid && !vec_is_reset && vec_source == 5'h00 |-> vec_high_addr == 16'hFFFC; endproperty
    a_swi: assert property (p_swi) else $error("software vector");
    property p_rst; vec_valid && vec_is_reset |-> vec_high_addr == 16'hFFFE && vec_source == 5'h00; endproperty
    a_rst: assert property (p_rst) else $error("reset vector");
    property p_hold; s_wait |=> vec_valid && $stable(vec_high_addr) && $stable(vec_source); endproperty
    a_hold: assert property (p_hold) else $error("offer not held");
    property p_drop; vec_valid && vec_ack |=> !vec_valid; endproperty
    a_drop: assert property (p_drop) else $error("offer not dropped");
    property p_prio; s_new |-> !$past(swi_req) && !$past(irq_mask)
        && ($past(irq_req) & ((20'h1 << (vec_source - 5'h1)) - 20'h1)) == 20'h0; endproperty
    a_prio: assert property (p_prio) else $error("lower flag won");
    property p_one; !$past(rst) |-> pending_flags_reg_one == {$past(irq_req[6:1]), 2'h0}; endproperty
    a_one: assert property (p_one) else $error("flag view one");
    // Views two and three follow the request lines one cycle late
    property p_two; !$past(rst) |-> pending_flags_reg_two == $past(irq_req[14:7]); endproperty
    a_two: assert property (p_two) else $error("flag view two");
    property p_three; !$past(rst) |-> pending_flags_reg_three == {2'h0, $past(irq_req[20:15])}; endproperty
    a_three: assert property (p_three) else $error("flag view three");
endmodule
`default_nettype wire

// file: sim/int_vec_map_tb.sv
// Self-checking bench for the vector map
`timescale 1ns/1ps
`default_nettype none
module int_vec_map_tb;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        swi_req = 1'b0;
    logic        irq_mask = 1'b0;
    logic [3:0]  lat = 4'h0;
    logic [20:1] irq_req = 20'h00000;
    logic        vec_ack, vec_valid, vec_is_reset;
    logic [4:0]  vec_source;
    logic [15:0] vec_high_addr, vec_low_addr;
    logic [7:0]  pending_flags_reg_one, pending_flags_reg_two, pending_flags_reg_three;
    int          errors = 0;
    int          checked = 0;
    int_vec_map dut (.mclk, .rst, .irq_req, .swi_req, .irq_mask, .vec_ack, .vec_valid, .vec_source,
        .vec_high_addr, .vec_low_addr, .vec_is_reset, .pending_flags_reg_one, .pending_flags_reg_two,
        .pending_flags_reg_three);
    core_model core (.mclk, .rst, .vec_valid, .lat, .vec_ack);
    always #25 mclk = ~mclk;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Wait for the offer the core takes, judge it, then step one cycle
    task automatic take(input logic [15:0] hi, input logic [4:0] src);
        int n;
        n = 0;
        while (!(vec_valid === 1'b1 && vec_ack === 1'b1)) begin
            @(negedge mclk);
            n++;
            if (n > 40) begin
                chk(16'h0000, 16'hFFFF);
                tally_and_finish();
            end
        end
        chk(vec_high_addr, hi);
        chk(vec_low_addr, hi + 16'h0001);
        chk({11'h000, vec_source}, {11'h000, src});
        @(negedge mclk);
    endtask
    // Views clear in reset, reset vector first
    task automatic t_reset;
        chk({pending_flags_reg_one, pending_flags_reg_two}, 16'h0000);
        chk({8'h00, pending_flags_reg_three}, 16'h0000);
        chk({14'h0000, vec_is_reset, vec_valid}, 16'h0002);
        rst = 1'b0;
        take(16'hFFFE, 5'h00);
        chk({15'h0000, vec_is_reset}, 16'h0000);
    endtask
    // Every flag alone, with fast and slow acknowledge
    task automatic t_map;
        for (int n = 1; n <= 20; n++) begin
            lat = 4'(n % 3);
            irq_req = 20'h1 << (n - 1);
            take(16'hFFFC - 16'(2 * n), 5'(n));
            irq_req = 20'h00000;
        end
    endtask
    // Masked flags: views follow, software wins, nothing else offered
    task automatic t_mask;
        irq_mask = 1'b1;
        swi_req = 1'b1;
        irq_req = 20'hFFFFF;
        @(negedge mclk);
        chk({pending_flags_reg_one, pending_flags_reg_two}, 16'hFCFF);
        chk({8'h00, pending_flags_reg_three}, 16'h003F);
        take(16'hFFFC, 5'h00);
        swi_req = 1'b0;
        repeat (5) @(negedge mclk);
        chk({15'h0000, vec_valid}, 16'h0000);
    endtask
    // Two flags pending: lower number first, then the other
    task automatic t_prio;
        irq_req = 20'h80004;
        irq_mask = 1'b0;
        take(16'hFFF6, 5'h03);
        irq_req = 20'h80000;
        take(16'hFFD4, 5'h14);
        irq_req = 20'h00000;
    endtask
    initial begin
        repeat (6) @(negedge mclk);
        t_reset();
        t_map();
        t_mask();
        t_prio();
        tally_and_finish();
    end
endmodule
bind int_vec_map int_vec_map_asserts chk_i (.mclk, .rst, .irq_req, .swi_req, .irq_mask, .vec_ack, .vec_valid,
    .vec_source, .vec_high_addr, .vec_low_addr, .vec_is_reset, .pending_flags_reg_one, .pending_flags_reg_two,
    .pending_flags_reg_three);
`default_nettype wire
